// ==== logic/pwmos_top.sv ====
// PWM output stage: trigger gating, one-shot extension, output steering,
// dead time, shutdown states and pin polarity, with an APB register port.
// Assumes the timebase supplies the raw PWM level, period and tick strobes.
// Operation
// - With triggered operation on and the gate bit set, enabled pins stay undriven until a trigger, except groups driven by a 1x shutdown state.
// - The one-shot count n stretches a one-shot event to n+1 timer periods.
// - The mode field selects single, push-pull, half-bridge, brush reverse/forward or scan; 011 and 111 are reserved.
// - The first polarity bit makes pins A, C and E active-low when set.
// - The second polarity bit makes pins B, D and F active-low when set.
// - On shutdown, A, C and E go active for 11, inactive for 10 and undriven for 0x.
// - On shutdown, B, D and F follow their own field with the same coding.
// - The dead-time field inserts 1 to 63 dead periods between complementary outputs; 0 disables it.
// - Mode, B/D/F polarity and shutdown, and dead-time fields exist only in the multi-output variant.
// - Unused bits of the control register read zero and all fields reset to zero.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module pwmos_top #(
	parameter bit P_MULTI_OUTPUT = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_pwm_raw,
	input wire logic i_period_end,
	input wire logic i_timer_tick,
	input wire logic i_triggered_operation_enable,
	input wire logic i_trigger,
	input wire logic i_oneshot_event,
	input wire logic i_shutdown,
	output logic o_oneshot_active,
	output logic [5:0] o_pwm_out,
	output logic [5:0] o_pwm_out_oe
);
	typedef struct packed {
		logic [31:0] ctrl3;
		logic [5:0] steer;
		logic [31:0] prdata;
		logic triggered;
		logic os_active;
		logic [2:0] os_cnt;
		logic phase;
		logic [2:0] scan_idx;
		logic [5:0] pins;
		logic [5:0] oe;
	} pwmos_state_t;

	pwmos_state_t st_reg;
	pwmos_state_t st_next;
	logic dt_high;
	logic dt_low;
	logic address_ok;

	// ==========================================
	// Helpers
	function automatic logic [31:0] ctrl3_mask();
		ctrl3_mask = P_MULTI_OUTPUT ? pwmos_pkg::CTRL3_MASK_MULTI : pwmos_pkg::CTRL3_MASK_SINGLE;
	endfunction

	function automatic logic [2:0] next_scan(input logic [2:0] idx, input logic [5:0] en);
		logic [2:0] cand;
		next_scan = idx;
		cand = idx;
		for (int k = 0; k < 6; k++) begin
			cand = (cand == 3'h5) ? 3'h0 : cand + 3'h1;
			if (en[cand] && next_scan == idx) begin
				next_scan = cand;
			end
		end
	endfunction

	function automatic logic [5:0] shut_group(input logic [5:0] grp, input logic [1:0] pss,
			input logic [5:0] val);
		shut_group = val;
		if (pss == pwmos_pkg::PSS_ACTIVE) begin
			shut_group = val | grp;
		end else if (pss == pwmos_pkg::PSS_INACTIVE) begin
			shut_group = val & ~grp;
		end
	endfunction

	function automatic logic [31:0] read_word(input logic [7:0] addr, input pwmos_state_t s);
		read_word = 32'h0000_0000;
		unique case (addr)
			pwmos_pkg::ADDR_CTRL3: read_word = s.ctrl3;
			pwmos_pkg::ADDR_STEER: read_word = {26'h000_0000, s.steer};
			pwmos_pkg::ADDR_STATUS: read_word = {13'h0000, s.triggered, s.os_active, i_shutdown,
					s.phase, s.scan_idx, s.pins, s.oe};
			default: read_word = 32'h0000_0000;
		endcase
	endfunction

	// ==========================================
	// Control fields
	logic gate_bit;
	logic [2:0] oneshot_extend_count;
	logic [2:0] mode;
	logic pol_ace;
	logic pol_bdf;
	logic [1:0] pss_ace;
	logic [1:0] pss_bdf;
	logic [5:0] dead_cycles;

	assign gate_bit = st_reg.ctrl3[pwmos_pkg::CTRL3_GATE_BIT];
	assign oneshot_extend_count = st_reg.ctrl3[pwmos_pkg::CTRL3_ONESHOT_EXTEND_COUNT_LSB +: 3];
	assign mode = st_reg.ctrl3[pwmos_pkg::CTRL3_MODE_LSB +: 3];
	assign pol_ace = st_reg.ctrl3[pwmos_pkg::CTRL3_POL_ACE_BIT];
	assign pol_bdf = st_reg.ctrl3[pwmos_pkg::CTRL3_POL_BDF_BIT];
	assign pss_ace = st_reg.ctrl3[pwmos_pkg::CTRL3_PSS_ACE_LSB +: 2];
	assign pss_bdf = st_reg.ctrl3[pwmos_pkg::CTRL3_PSS_BDF_LSB +: 2];
	assign dead_cycles = st_reg.ctrl3[pwmos_pkg::CTRL3_DT_LSB +: 6];

	// ==========================================
	// Complementary pair
	pwmos_deadtime u_deadtime (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_pwm(i_pwm_raw),
		.i_dead_cycles(dead_cycles),
		.o_high(dt_high),
		.o_low(dt_low)
	);

	// ==========================================
	// APB handshake
	assign address_ok = (i_paddr == pwmos_pkg::ADDR_CTRL3) || (i_paddr == pwmos_pkg::ADDR_STEER)
			|| (i_paddr == pwmos_pkg::ADDR_STATUS);
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !address_ok;
	assign o_prdata = st_reg.prdata;

	// ==========================================
	// Next state
	logic [5:0] level;
	logic [5:0] drive;
	logic [5:0] pol_mask;

	always_comb begin
		st_next = st_reg;
		level = 6'h00;
		drive = 6'h00;
		pol_mask = 6'h00;

		// Register port
		if (i_psel && !i_penable) begin
			st_next.prdata = read_word(i_paddr, st_reg);
		end
		if (i_psel && i_penable && i_pwrite) begin
			if (i_paddr == pwmos_pkg::ADDR_CTRL3) begin
				st_next.ctrl3 = i_pwdata & ctrl3_mask();
			end else if (i_paddr == pwmos_pkg::ADDR_STEER) begin
				st_next.steer = i_pwdata[5:0];
			end
		end

		// Trigger arming, the trigger wins over a disarm in the same cycle
		if (i_trigger) begin
			st_next.triggered = 1'b1;
		end else if (!i_triggered_operation_enable) begin
			st_next.triggered = 1'b0;
		end

		// One-shot extension
		if (i_oneshot_event) begin
			st_next.os_active = 1'b1;
			st_next.os_cnt = oneshot_extend_count;
		end else if (st_reg.os_active && i_timer_tick) begin
			if (st_reg.os_cnt == 3'h0) begin
				st_next.os_active = 1'b0;
			end else begin
				st_next.os_cnt = st_reg.os_cnt - 3'h1;
			end
		end

		// Period sequencing for push-pull and scan
		if (i_period_end) begin
			st_next.phase = ~st_reg.phase;
			if (mode == pwmos_pkg::MODE_SCAN) begin
				st_next.scan_idx = next_scan(st_reg.scan_idx, st_reg.steer);
			end
		end
		if (st_reg.scan_idx > 3'h5) begin
			st_next.scan_idx = 3'h0;
		end

		// Output arrangement
		unique case (mode)
			pwmos_pkg::MODE_SINGLE: begin
				drive = st_reg.steer;
				level = dt_high ? st_reg.steer : 6'h00;
			end
			pwmos_pkg::MODE_PUSH_PULL: begin
				drive = 6'h03;
				level = {4'h0, dt_high && !st_reg.phase, dt_high && st_reg.phase};
			end
			pwmos_pkg::MODE_HALF_BRIDGE: begin
				drive = 6'h03;
				level = {4'h0, dt_low, dt_high};
			end
			pwmos_pkg::MODE_BRUSH_REV: begin
				drive = 6'h0F;
				level = {4'h0, dt_high, 1'b0} | 6'h04;
			end
			pwmos_pkg::MODE_BRUSH_FWD: begin
				drive = 6'h0F;
				level = {2'h0, dt_high, 3'h0} | 6'h01;
			end
			pwmos_pkg::MODE_SCAN: begin
				drive = st_reg.steer;
				level = dt_high ? (6'h01 << st_reg.scan_idx) & st_reg.steer : 6'h00;
			end
			default: begin
				drive = 6'h00;
				level = 6'h00;
			end
		endcase

		// Shutdown overrides the arrangement
		if (i_shutdown) begin
			level = shut_group(pwmos_pkg::GROUP_ACE, pss_ace, level);
			level = shut_group(pwmos_pkg::GROUP_BDF, pss_bdf, level);
			if (pss_ace[1]) begin
				drive = drive | pwmos_pkg::GROUP_ACE;
			end else begin
				drive = drive & ~pwmos_pkg::GROUP_ACE;
			end
			if (pss_bdf[1]) begin
				drive = drive | pwmos_pkg::GROUP_BDF;
			end else begin
				drive = drive & ~pwmos_pkg::GROUP_BDF;
			end
		end else if (i_triggered_operation_enable && gate_bit && !st_reg.triggered) begin
			drive = 6'h00;
		end

		// Polarity last so shutdown states follow it
		if (pol_ace) begin
			pol_mask = pol_mask | pwmos_pkg::GROUP_ACE;
		end
		if (pol_bdf) begin
			pol_mask = pol_mask | pwmos_pkg::GROUP_BDF;
		end
		st_next.pins = level ^ pol_mask;
		st_next.oe = drive;
	end

	// ==========================================
	// State register
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_reg <= '0;
			st_reg.ctrl3 <= pwmos_pkg::CTRL3_RESET;
			st_reg.steer <= pwmos_pkg::STEER_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_oneshot_active = st_reg.os_active;
	assign o_pwm_out = st_reg.pins;
	assign o_pwm_out_oe = st_reg.oe;
endmodule

// ==== logic/pwmos_pkg.sv ====
// Constants for the PWM output stage: register map, field positions,
// reset values and output arrangement codes.
// Assumes a 32-bit APB slave with byte addresses, one word per register.
package pwmos_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0] ADDR_CTRL3 = 8'h00;
	localparam logic [7:0] ADDR_STEER = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// ==========================================
	// Output control register fields
	localparam int CTRL3_GATE_BIT = 31;
	localparam int CTRL3_ONESHOT_EXTEND_COUNT_LSB = 28;
	localparam int CTRL3_MODE_LSB = 24;
	localparam int CTRL3_POL_ACE_BIT = 21;
	localparam int CTRL3_POL_BDF_BIT = 20;
	localparam int CTRL3_PSS_ACE_LSB = 18;
	localparam int CTRL3_PSS_BDF_LSB = 16;
	localparam int CTRL3_DT_LSB = 0;
	localparam logic [31:0] CTRL3_MASK_MULTI = 32'hF73F_003F;
	localparam logic [31:0] CTRL3_MASK_SINGLE = 32'hF02C_0000;
	localparam logic [31:0] CTRL3_RESET = 32'h0000_0000;

	// ==========================================
	// Steering register
	localparam logic [5:0] STEER_RESET = 6'h01;

	// ==========================================
	// Output arrangement codes
	localparam logic [2:0] MODE_SINGLE = 3'h0;
	localparam logic [2:0] MODE_PUSH_PULL = 3'h1;
	localparam logic [2:0] MODE_HALF_BRIDGE = 3'h2;
	localparam logic [2:0] MODE_BRUSH_REV = 3'h4;
	localparam logic [2:0] MODE_BRUSH_FWD = 3'h5;
	localparam logic [2:0] MODE_SCAN = 3'h6;

	// Shutdown state codes, upper bit clear means high impedance
	localparam logic [1:0] PSS_ACTIVE = 2'h3;
	localparam logic [1:0] PSS_INACTIVE = 2'h2;

	// Pin group masks, bit 0 is output A
	localparam logic [5:0] GROUP_ACE = 6'h15;
	localparam logic [5:0] GROUP_BDF = 6'h2A;
endpackage

// ==== logic/pwmos_deadtime.sv ====
// Dead-time inserter: splits one PWM level into a complementary pair.
// Assumes the PWM input is synchronous to i_clk.
`timescale 1ns/100ps
module pwmos_deadtime (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_pwm,
	input wire logic [5:0] i_dead_cycles,
	output logic o_high,
	output logic o_low
);
	typedef struct packed {
		logic prev;
		logic [5:0] cnt;
		logic high;
		logic low;
	} pwmos_dt_state_t;

	pwmos_dt_state_t st_reg;
	pwmos_dt_state_t st_next;

	// ==========================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.prev = i_pwm;
		if (i_dead_cycles == 6'h00) begin
			// Dead-time logic disabled, plain complement
			st_next.cnt = 6'h00;
			st_next.high = i_pwm;
			st_next.low = ~i_pwm;
		end else if (i_pwm != st_reg.prev) begin
			// Both sides off for the programmed count
			st_next.high = 1'b0;
			st_next.low = 1'b0;
			st_next.cnt = i_dead_cycles - 6'h01;
		end else if (st_reg.cnt != 6'h00) begin
			st_next.cnt = st_reg.cnt - 6'h01;
		end else begin
			st_next.high = st_reg.prev;
			st_next.low = ~st_reg.prev;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_high = st_reg.high;
	assign o_low = st_reg.low;
endmodule

// ==== bench/pwmos_top_asserts.sv ====
// Checker for the PWM output stage, bound to the top module.
// Assumes APB writes land at the access edge; mirrors the control word.
`timescale 1ns/100ps
module pwmos_top_asserts #(
	parameter bit P_MULTI_OUTPUT = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_pwm_raw,
	input wire logic i_period_end,
	input wire logic i_timer_tick,
	input wire logic i_triggered_operation_enable,
	input wire logic i_trigger,
	input wire logic i_oneshot_event,
	input wire logic i_shutdown,
	input wire logic o_oneshot_active,
	input wire logic [5:0] o_pwm_out,
	input wire logic [5:0] o_pwm_out_oe
);
	// ==========================================
	// Control word mirror and tick counter
	logic [31:0] mask;
	logic [31:0] cfg_reg;
	logic [2:0] tick_reg;
	localparam logic [5:0] ACE = pwmos_pkg::GROUP_ACE;
	localparam logic [5:0] BDF = pwmos_pkg::GROUP_BDF;
	assign mask = P_MULTI_OUTPUT ? pwmos_pkg::CTRL3_MASK_MULTI : pwmos_pkg::CTRL3_MASK_SINGLE;
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cfg_reg <= 32'h0000_0000;
			tick_reg <= 3'h0;
		end else begin
			if (i_psel && i_penable && i_pwrite && i_paddr == pwmos_pkg::ADDR_CTRL3) begin
				cfg_reg <= i_pwdata & mask;
			end
			tick_reg <= o_oneshot_active ? tick_reg + 3'(i_timer_tick) : 3'h0;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// ==========================================
	// Assertions
	AST_GATE: assert property (!$past(i_triggered_operation_enable) && i_triggered_operation_enable
		&& cfg_reg[31] && !i_trigger && !i_shutdown |=> o_pwm_out_oe == 6'h00) else $error("pins driven before trigger");
	AST_RSVD: assert property ((cfg_reg[26:24] == 3'h3 || cfg_reg[26:24] == 3'h7) && !i_shutdown
		|=> o_pwm_out_oe == 6'h00) else $error("reserved mode drives pins");
	AST_SHUT_Z: assert property (i_shutdown && !cfg_reg[19] |=> (o_pwm_out_oe & ACE) == 6'h00)
		else $error("ace not released in shutdown");
	AST_SHUT_ON: assert property (i_shutdown && cfg_reg[19:18] == pwmos_pkg::PSS_ACTIVE |=>
		(o_pwm_out_oe & ACE) == ACE && (o_pwm_out & ACE) == (cfg_reg[21] ? 6'h00 : ACE)) else $error("ace not active");
	AST_SHUT_OFF: assert property (i_shutdown && cfg_reg[17:16] == pwmos_pkg::PSS_INACTIVE |=>
		(o_pwm_out_oe & BDF) == BDF && (o_pwm_out & BDF) == (cfg_reg[20] ? BDF : 6'h00)) else $error("bdf not inactive");
	AST_OS_START: assert property (i_oneshot_event |=> o_oneshot_active) else $error("one-shot not started");
	AST_OS_END: assert property (o_oneshot_active && i_timer_tick && !i_oneshot_event
		&& tick_reg == cfg_reg[30:28] |=> !o_oneshot_active) else $error("one-shot too long");
	AST_OS_EARLY: assert property ($fell(o_oneshot_active) |-> $past(i_timer_tick)
		&& $past(tick_reg) == $past(cfg_reg[30:28])) else $error("one-shot too short");
	AST_RD: assert property (i_psel && i_penable && !i_pwrite && i_paddr == pwmos_pkg::ADDR_CTRL3
		|-> (o_prdata & ~mask) == 32'h0000_0000) else $error("unused bits read nonzero");
	cover property (i_shutdown && cfg_reg[19:18] == pwmos_pkg::PSS_ACTIVE);
	cover property ($fell(o_oneshot_active));
	cover property (i_trigger && cfg_reg[31]);
endmodule
bind pwmos_top pwmos_top_asserts #(.P_MULTI_OUTPUT(P_MULTI_OUTPUT)) u_chk (.i_clk(i_clk), .i_reset(i_reset),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pwm_raw(i_pwm_raw),
	.i_period_end(i_period_end), .i_timer_tick(i_timer_tick), .i_trigger(i_trigger),
	.i_triggered_operation_enable(i_triggered_operation_enable), .i_oneshot_event(i_oneshot_event),
	.i_shutdown(i_shutdown), .o_oneshot_active(o_oneshot_active), .o_pwm_out(o_pwm_out), .o_pwm_out_oe(o_pwm_out_oe));

// ==== bench/pwmos_bridge_model.sv ====
// Bridge stage on the six output pins: resolves each line level.
// Assumes no pull resistors, so a released line wanders.
`timescale 1ns/100ps
module pwmos_bridge_model (
	input wire logic i_clk,
	input wire logic [5:0] i_pin,
	input wire logic [5:0] i_oe,
	output logic [5:0] o_line
);
	logic alt_reg = 1'h0;
	always_ff @(posedge i_clk) begin
		alt_reg <= !alt_reg;
	end
	// Released line toggles, never holds last level
	always_comb begin
		for (int k = 0; k < 6; k++) o_line[k] = i_oe[k] ? i_pin[k] : alt_reg;
	end
endmodule

// ==== bench/pwm_output_stage_control_test.sv ====
// Self-checking bench for the PWM output stage.
// Assumes the checker is bound and the bridge model loads the pins.
`timescale 1ns/100ps
module pwm_output_stage_control_test;
	logic clk, rst, psel, pen, pwr, pwm, pend, tick, ten, trig, os, shut, rdy, err, e, os_act;
	logic [7:0] addr;
	logic [31:0] wdata, prdata, rd;
	logic [5:0] pins, oe, lines;
	int n_errors = 0;
	int compares = 0;
	pwmos_top dut (.i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
		.i_pwdata(wdata), .o_prdata(prdata), .o_pready(rdy), .o_pslverr(err), .i_pwm_raw(pwm), .i_period_end(pend),
		.i_timer_tick(tick), .i_triggered_operation_enable(ten), .i_trigger(trig), .i_oneshot_event(os),
		.i_shutdown(shut), .o_oneshot_active(os_act), .o_pwm_out(pins), .o_pwm_out_oe(oe));
	pwmos_bridge_model bridge (.i_clk(clk), .i_pin(pins), .i_oe(oe), .o_line(lines));
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (rdy !== 1'h1);
		rd = prdata;
		e = err;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task automatic t_regs;
		apb(1'h0, 8'h00, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'h1, 8'h00, 32'hFFFF_FFFF);
		apb(1'h0, 8'h00, 32'h0000_0000);
		chk(rd, 32'hF73F_003F);
		apb(1'h0, 8'h10, 32'h0000_0000);
		chk({rd[30:0], e}, 32'h0000_0001);
	endtask
	task automatic t_shut;
		logic [31:0] cfg [3] = '{32'h000E_0000, 32'h002B_0000, 32'h0017_0000};
		logic [5:0] x_oe [3] = '{6'h3F, 6'h3F, 6'h2A};
		logic [5:0] x_pin [3] = '{6'h15, 6'h3F, 6'h00};
		for (int i = 0; i < 3; i++) begin
			apb(1'h1, 8'h00, cfg[i]);
			shut <= 1'h1;
			repeat (3) @(posedge clk);
			chk(oe, x_oe[i]);
			chk(lines & oe, x_pin[i]);
			shut <= 1'h0;
		end
	endtask
	task automatic t_gate;
		apb(1'h1, 8'h00, 32'h8000_0000);
		ten <= 1'h1;
		repeat (4) @(posedge clk);
		chk(oe, 6'h00);
		trig <= 1'h1;
		@(posedge clk);
		trig <= 1'h0;
		repeat (3) @(posedge clk);
		chk(oe, 6'h01);
		ten <= 1'h0;
		apb(1'h1, 8'h00, 32'h0000_0000);
		ten <= 1'h1;
		repeat (4) @(posedge clk);
		chk(oe, 6'h01);
		ten <= 1'h0;
	endtask
	task automatic t_oneshot;
		logic [2:0] n [2] = '{3'h0, 3'h7};
		int cnt;
		for (int i = 0; i < 2; i++) begin
			apb(1'h1, 8'h00, {1'h0, n[i], 28'h000_0000});
			os <= 1'h1;
			@(posedge clk);
			os <= 1'h0;
			@(posedge clk);
			chk(os_act, 1'h1);
			cnt = 0;
			repeat (9) begin
				tick <= 1'h1;
				@(posedge clk);
				tick <= 1'h0;
				repeat (2) @(posedge clk);
				if (os_act === 1'h1) cnt++;
			end
			chk(cnt, n[i]);
		end
	endtask
	task automatic t_deadtime;
		logic [5:0] dt [2] = '{6'h00, 6'h05};
		int cnt;
		for (int i = 0; i < 2; i++) begin
			pwm <= 1'h0;
			apb(1'h1, 8'h00, {5'h00, 3'h2, 18'h0_0000, dt[i]});
			repeat (10) @(posedge clk);
			pwm <= 1'h1;
			cnt = 0;
			repeat (16) begin
				@(posedge clk);
				if (pins[1:0] === 2'h0) cnt++;
			end
			chk(cnt, dt[i]);
			chk(pins[1:0], 2'h1);
		end
	endtask
	task automatic t_modes;
		logic [2:0] m [5] = '{3'h2, 3'h4, 3'h5, 3'h3, 3'h7};
		logic [5:0] x_oe [5] = '{6'h03, 6'h0F, 6'h0F, 6'h00, 6'h00};
		logic [5:0] x_pin [5] = '{6'h01, 6'h06, 6'h09, 6'h00, 6'h00};
		for (int i = 0; i < 5; i++) begin
			apb(1'h1, 8'h00, {5'h00, m[i], 24'h00_0000});
			repeat (4) @(posedge clk);
			chk(oe, x_oe[i]);
			chk(pins & oe, x_pin[i]);
		end
	endtask
	task automatic t_seq;
		apb(1'h1, 8'h00, 32'h0100_0000);
		repeat (4) @(posedge clk);
		chk(oe, 6'h03);
		chk(pins & oe, 6'h02);
		pend <= 1'h1;
		@(posedge clk);
		pend <= 1'h0;
		repeat (3) @(posedge clk);
		chk(pins & oe, 6'h01);
		apb(1'h1, 8'h04, 32'h0000_0005);
		apb(1'h1, 8'h00, 32'h0600_0000);
		repeat (4) @(posedge clk);
		chk(oe, 6'h05);
		chk(pins & oe, 6'h01);
		pend <= 1'h1;
		@(posedge clk);
		pend <= 1'h0;
		repeat (3) @(posedge clk);
		chk(pins & oe, 6'h04);
	endtask
	task automatic end_of_test;
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{rst, psel, pen, pwr, pwm, pend, tick, ten, trig, os, shut} = 11'h400;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		t_regs;
		t_shut;
		t_gate;
		t_oneshot;
		t_deadtime;
		t_modes;
		t_seq;
		end_of_test;
	end
	initial begin
		#100000;
		n_errors++;
		end_of_test;
	end
endmodule
